// >>> rtl/emi_core.sv
// Purpose: External memory bus interface, two-phase multiplexed cycles
// Assumes: Pin inputs synchronous to clock; each phase is one clock unless stalled
// Notes:   Reset wins over the clock enable
//
// Notes on behaviour
// R1: Every external cycle is an address phase then a data phase.
// R2: Address driven on both ports in address phase, held until next one.
// R3: Reads float the low port in data phase; data taken at strobe rise.
// R4: Writes drive data from data strobe fall until next address.
// R5: Data strobe low in data phase only for external accesses.
// R6: Address strobe active in address phase; its rise marks valid address.
// R7: Strobes and read/write float when granted away or float bit set.
// R8: During reset strobes stay high through weak pull-ups.
// R9: Top address bit picks upper block (data strobe) or lower block.
// R10: Read/write high for reads, low for writes, held until next cycle.
// R11: Bus request sampled in data phase when its enable bit is set.
// R12: Request low stalls and floats the bus; released when request high.
// R13: Grant goes low once the bus signals are floated.
// R14: Bus request disabled after reset until software enables it.
// R15: Low port carries address low byte and data; second port high byte.
// R16: Stall input sampled each clock when enabled; each low adds a clock.
// R17: Stall in address phase stretches address strobe, in data phase data.
// R18: Style bit gives latch pulse, output enable and write enable.
// R19: Second strobe enable moves lower-block strobing to the second strobe.
// R20: Address strobe reaches a shared pin only with its routing bit set.
// R21: Toggle bit lets pins move on internal accesses, never data strobes; here only while protect_off is also high.
// R22: Drive strength bit selects large or small output drivers.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module emi_core #(
    parameter int AW        = 22,
    parameter bit AS_SHARED = 1'b1
) (
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic          clk_en,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          acc_req,
    input  wire logic          acc_write,
    input  wire logic          acc_internal,
    input  wire logic [AW-1:0] acc_addr,
    input  wire logic [7:0]    acc_wdata,
    output logic               acc_done,
    output logic      [7:0]    acc_rdata,
    output logic               acc_busy,
    input  wire logic          protect_off,
    input  wire logic [7:0]    ad_in,
    output logic      [7:0]    ad_out,
    output logic               ad_oe,
    output logic      [7:0]    addr_hi_out,
    output logic               addr_hi_oe,
    output logic               addr_top_out,
    output logic               addr_top_oe,
    output logic               addr_strobe_n_out,
    output logic               addr_strobe_n_oe,
    output logic               data_strobe_n_out,
    output logic               data_strobe_n_oe,
    output logic               lower_block_strobe_n_out,
    output logic               lower_block_strobe_n_oe,
    output logic               rw_n_out,
    output logic               rw_n_oe,
    input  wire logic          stall_n,
    input  wire logic          bus_request_n,
    output logic               bus_grant_n,
    output logic               drive_strength,
    output logic               weak_pullup_en
);
    // ****************************************
    // Register file
    // ****************************************
    logic [7:0] cfg_reg;
    logic [7:0] mode_reg;
    logic       sel_cfg;
    logic       sel_mode;
    logic       sel_stat;
    logic       unmapped;
    logic       apb_done;

    emi_apb_dec u_dec (
        .paddr    (paddr),
        .sel_cfg  (sel_cfg),
        .sel_mode (sel_mode),
        .sel_stat (sel_stat),
        .unmapped (unmapped)
    );

    emi_pkg::emi_state_t state_reg;
    emi_pkg::emi_state_t state_next;

    assign apb_done = psel && penable && pready;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else if (clk_en) begin
            // One wait-free access phase per transfer
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfg_reg  <= emi_pkg::CFG1_RST;
            mode_reg <= emi_pkg::MODE_RST; // [R14]
        end else if (clk_en && apb_done && pwrite) begin
            if (sel_cfg) begin
                cfg_reg <= (pwdata[7:0] & emi_pkg::CFG1_WMASK)
                         | (cfg_reg & ~emi_pkg::CFG1_WMASK);
            end
            if (sel_mode) begin
                mode_reg <= pwdata[7:0] & emi_pkg::MODE_WMASK;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pslverr <= psel && !penable && unmapped;
            if (psel && !penable) begin
                if (sel_cfg) begin
                    prdata <= {24'h00_0000, cfg_reg};
                end else if (sel_mode) begin
                    prdata <= {24'h00_0000, mode_reg};
                end else if (sel_stat) begin
                    prdata <= {27'h000_0000, !bus_grant_n, state_reg};
                end else begin
                    prdata <= 32'h0000_0000;
                end
            end
        end
    end

    // ****************************************
    // Cycle sequencer
    // ****************************************
    logic          stall_on;
    logic          brq_on;
    logic          write_reg;
    logic          intern_reg;
    logic [AW-1:0] addr_reg;
    logic [7:0]    wdata_reg;

    assign stall_on = mode_reg[emi_pkg::MODE_STALL] && !stall_n; // [R16]
    assign brq_on   = mode_reg[emi_pkg::MODE_BUS_REQUEST_ENABLE] && !bus_request_n; // [R11]

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            emi_pkg::EMI_IDLE: begin
                if (acc_req) begin
                    state_next = emi_pkg::EMI_ADDR;
                end
            end
            emi_pkg::EMI_ADDR: begin
                // Stall here stretches the address strobe
                if (!stall_on) begin
                    state_next = emi_pkg::EMI_DATA; // [R1] [R17]
                end
            end
            emi_pkg::EMI_DATA: begin
                if (stall_on) begin
                    state_next = emi_pkg::EMI_DATA; // [R17]
                end else if (brq_on) begin
                    state_next = emi_pkg::EMI_HOLD; // [R12]
                end else begin
                    state_next = emi_pkg::EMI_IDLE;
                end
            end
            emi_pkg::EMI_HOLD: begin
                if (bus_request_n) begin
                    state_next = emi_pkg::EMI_IDLE; // [R12]
                end
            end
            default: state_next = emi_pkg::EMI_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= emi_pkg::EMI_IDLE;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            write_reg  <= 1'b0;
            intern_reg <= 1'b0;
            addr_reg   <= '0;
            wdata_reg  <= 8'h00;
        end else if (clk_en && state_reg == emi_pkg::EMI_IDLE && acc_req) begin
            write_reg  <= acc_write;
            intern_reg <= acc_internal;
            addr_reg   <= acc_addr;
            wdata_reg  <= acc_wdata;
        end
    end

    // Read data taken at the edge where the data strobe rises
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            acc_done  <= 1'b0;
            acc_rdata <= 8'h00;
            acc_busy  <= 1'b0;
        end else if (clk_en) begin
            acc_done <= state_reg == emi_pkg::EMI_DATA && !stall_on;
            acc_busy <= state_next != emi_pkg::EMI_IDLE;
            if (state_reg == emi_pkg::EMI_DATA && !stall_on && !write_reg
                && !intern_reg) begin
                acc_rdata <= ad_in; // [R3]
            end
        end
    end

    // ****************************************
    // Pin values for the coming cycle
    // ****************************************
    logic          n_write;
    logic          n_intern;
    logic [AW-1:0] n_addr;
    logic [7:0]    n_wdata;
    logic          n_ap;
    logic          n_dp;
    logic          n_vis;
    logic          n_ext;
    logic          n_flt;
    logic          as_c;
    logic          ds_c;
    logic          output_enable_n;
    logic          use_low;
    logic          as_d;
    logic          ds_d;
    logic          ds2_d;
    logic          rw_d;
    logic          rw_load;
    logic          ad_load;
    logic [7:0]    ad_d;
    logic          ad_en;
    logic          as_en;

    always_comb begin
        if (state_reg == emi_pkg::EMI_IDLE && acc_req) begin
            n_write  = acc_write;
            n_intern = acc_internal;
            n_addr   = acc_addr;
            n_wdata  = acc_wdata;
        end else begin
            n_write  = write_reg;
            n_intern = intern_reg;
            n_addr   = addr_reg;
            n_wdata  = wdata_reg;
        end
        n_ext = !n_intern;
        // Internal cycles show on the pins only when allowed
        n_vis = n_ext || (cfg_reg[emi_pkg::CFG_TOGGLE] && protect_off); // [R21]
        n_ap  = state_next == emi_pkg::EMI_ADDR && n_vis;
        n_dp  = state_next == emi_pkg::EMI_DATA;
        n_flt = mode_reg[emi_pkg::MODE_FLOAT]
              || state_next == emi_pkg::EMI_HOLD; // [R7] [R12]
        as_c    = !n_ap; // [R6]
        ds_c    = !(n_dp && n_ext); // [R5] [R21]
        use_low = cfg_reg[emi_pkg::CFG_SECOND_STROBE_ENABLE] && !n_addr[AW-1]; // [R9] [R19]
        if (cfg_reg[emi_pkg::CFG_STYLE]) begin
            as_d    = !as_c; // [R18]
            output_enable_n     = n_write ? 1'b1 : ds_c;
            rw_d    = n_write ? ds_c : 1'b1;
            rw_load = 1'b1;
        end else begin
            as_d    = as_c;
            output_enable_n     = ds_c;
            rw_d    = !n_write; // [R10]
            rw_load = n_ap;
        end
        ds_d  = use_low ? 1'b1 : output_enable_n; // [R19]
        ds2_d = use_low ? output_enable_n : 1'b1;
        as_en = cfg_reg[emi_pkg::CFG_STROBE_PIN_ALTFUNC] || !AS_SHARED; // [R20]
        ad_load = 1'b0;
        ad_d    = n_addr[7:0];
        ad_en   = 1'b1;
        if (n_ap) begin
            ad_load = 1'b1; // [R2] [R15]
        end else if (n_dp && n_ext && n_write) begin
            ad_load = 1'b1;
            ad_d    = n_wdata; // [R4]
        end else if (n_dp && n_ext) begin
            ad_load = 1'b1;
            ad_en   = 1'b0; // [R3]
        end
    end

    // ****************************************
    // Pins
    // ****************************************
    emi_pin #(.W(8), .RST(8'h00)) u_ad (
        .clock  (clock),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .load   (ad_load),
        .d      (ad_d),
        .en_d   (ad_en),
        .flt    (n_flt),
        .q      (ad_out),
        .oe     (ad_oe)
    );

    emi_pin #(.W(9), .RST(9'h000)) u_hi (
        .clock  (clock),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .load   (n_ap),
        .d      ({n_addr[AW-1], n_addr[15:8]}),
        .en_d   (1'b1),
        .flt    (n_flt),
        .q      ({addr_top_out, addr_hi_out}),
        .oe     (addr_hi_oe)
    );
    assign addr_top_oe = addr_hi_oe;

    // Strobes reset high; pull-ups carry them while reset leaves them undriven
    emi_pin #(.W(1), .RST(1'b1)) u_as (
        .clock  (clock),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .load   (1'b1),
        .d      (as_d),
        .en_d   (as_en),
        .flt    (n_flt),
        .q      (addr_strobe_n_out),
        .oe     (addr_strobe_n_oe)
    );

    emi_pin #(.W(1), .RST(1'b1)) u_ds (
        .clock  (clock),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .load   (1'b1),
        .d      (ds_d),
        .en_d   (1'b1),
        .flt    (n_flt),
        .q      (data_strobe_n_out),
        .oe     (data_strobe_n_oe)
    );

    emi_pin #(.W(1), .RST(1'b1)) u_ds2 (
        .clock  (clock),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .load   (1'b1),
        .d      (ds2_d),
        .en_d   (1'b1),
        .flt    (n_flt),
        .q      (lower_block_strobe_n_out),
        .oe     (lower_block_strobe_n_oe)
    );

    emi_pin #(.W(1), .RST(1'b1)) u_rw (
        .clock  (clock),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .load   (rw_load),
        .d      (rw_d),
        .en_d   (1'b1),
        .flt    (n_flt),
        .q      (rw_n_out),
        .oe     (rw_n_oe)
    );

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bus_grant_n    <= 1'b1;
            drive_strength <= 1'b0;
            weak_pullup_en <= 1'b1; // [R8]
        end else if (clk_en) begin
            bus_grant_n    <= state_next != emi_pkg::EMI_HOLD; // [R13]
            drive_strength <= cfg_reg[emi_pkg::CFG_DRIVE]; // [R22]
            weak_pullup_en <= 1'b0;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n || !clk_en);

    a_two_phase_seq: assert property ( // [R1]
        state_reg == emi_pkg::EMI_ADDR && !stall_on |=> state_reg == emi_pkg::EMI_DATA
    ) else $error("address phase not followed by data phase");

    a_stall_stretch: assert property ( // [R16]
        state_reg == emi_pkg::EMI_DATA && stall_on |=> state_reg == emi_pkg::EMI_DATA
    ) else $error("data phase not stretched by stall");

    a_ds_internal: assert property ( // [R5]
        state_reg == emi_pkg::EMI_DATA && intern_reg
        |-> data_strobe_n_out && lower_block_strobe_n_out
    ) else $error("data strobe moved on internal access");

    a_float_ctl: assert property ( // [R7]
        $past(mode_reg[emi_pkg::MODE_FLOAT]) |-> !addr_strobe_n_oe && !data_strobe_n_oe
        && !lower_block_strobe_n_oe && !rw_n_oe
    ) else $error("strobes driven while float set");

    a_grant_float: assert property ( // [R13]
        !bus_grant_n |-> !ad_oe && !addr_hi_oe && !rw_n_oe && !data_strobe_n_oe
    ) else $error("grant given while bus driven");

    a_bus_request_n_handover: assert property ( // [R12]
        state_reg == emi_pkg::EMI_DATA && !stall_on && brq_on
        |=> !bus_grant_n ##1 (bus_grant_n == $past(bus_request_n))
    ) else $error("bus request not honoured");

    a_rw_level: assert property ( // [R10]
        state_reg == emi_pkg::EMI_DATA && !intern_reg && !cfg_reg[emi_pkg::CFG_STYLE]
        && $stable(cfg_reg) |-> rw_n_out == !write_reg
    ) else $error("read/write level wrong");

    a_ds2_off: assert property ( // [R19]
        $past(!cfg_reg[emi_pkg::CFG_SECOND_STROBE_ENABLE]) |-> lower_block_strobe_n_out
    ) else $error("second strobe moved while disabled");

    a_read_float: assert property ( // [R3]
        state_reg == emi_pkg::EMI_DATA && !write_reg && !intern_reg |-> !ad_oe
    ) else $error("low port driven during read data phase");
endmodule

// >>> rtl/emi_pkg.sv
// Purpose: Shared constants and types for the external memory bus interface
// Assumes: APB with 32-bit data, register index times four gives byte address
// Notes:   Reserved configuration bits keep their reset value
package emi_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [9:0]  CFG1_IDX   = 10'h0f5;
    localparam logic [9:0]  MODE_IDX   = 10'h0f6;
    localparam logic [9:0]  STAT_IDX   = 10'h0f7;
    localparam logic [7:0]  CFG1_RST   = 8'h80;
    localparam logic [7:0]  CFG1_WMASK = 8'h76;
    localparam logic [7:0]  MODE_RST   = 8'h00;
    localparam logic [7:0]  MODE_WMASK = 8'h07;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CFG_STYLE  = 6;
    localparam int CFG_SECOND_STROBE_ENABLE  = 5;
    localparam int CFG_STROBE_PIN_ALTFUNC   = 4;
    localparam int CFG_TOGGLE = 2;
    localparam int CFG_DRIVE  = 1;
    localparam int MODE_FLOAT = 0;
    localparam int MODE_BUS_REQUEST_ENABLE = 1;
    localparam int MODE_STALL = 2;
    localparam int STAT_GRANT = 4;
    // ****************************************
    // Cycle states
    // ****************************************
    typedef enum logic [3:0] {
        EMI_IDLE = 4'h1,
        EMI_ADDR = 4'h2,
        EMI_DATA = 4'h4,
        EMI_HOLD = 4'h8
    } emi_state_t;
endpackage

// >>> rtl/emi_pin.sv
// Purpose: Registered output pin with remembered drive and float override
// Assumes: Float overrides drive without losing the remembered drive
// Notes:   Output and enable come straight from flip-flops
`timescale 1ns/1ps
module emi_pin #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '1
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic         load,
    input  wire logic [W-1:0] d,
    input  wire logic         en_d,
    input  wire logic         flt,
    output logic      [W-1:0] q,
    output logic              oe
);
    logic en_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q      <= RST;
            en_reg <= 1'b0;
            oe     <= 1'b0;
        end else if (clk_en) begin
            if (load) begin
                q      <= d;
                en_reg <= en_d;
            end
            oe <= (load ? en_d : en_reg) & ~flt;
        end
    end
endmodule

// >>> rtl/emi_apb_dec.sv
// Purpose: Word address decode for the interface registers
// Assumes: Byte address is four times the register index
// Notes:   Anything else is unmapped and answered with an error
`timescale 1ns/1ps
module emi_apb_dec (
    input  wire logic [11:0] paddr,
    output logic             sel_cfg,
    output logic             sel_mode,
    output logic             sel_stat,
    output logic             unmapped
);
    always_comb begin
        sel_cfg  = (paddr[11:2] == emi_pkg::CFG1_IDX) && (paddr[1:0] == 2'h0);
        sel_mode = (paddr[11:2] == emi_pkg::MODE_IDX) && (paddr[1:0] == 2'h0);
        sel_stat = (paddr[11:2] == emi_pkg::STAT_IDX) && (paddr[1:0] == 2'h0);
        unmapped = !(sel_cfg || sel_mode || sel_stat);
    end
endmodule

// >>> tb/emi_mem_model.sv
// Purpose: Behavioural byte memory on the far side of the multiplexed bus
// Assumes: Address low byte picks one of 256 locations; ale follows style bit
// Notes:   A released bus shows the inverse of its last value
`timescale 1ns/1ps
module emi_mem_model (
    input  wire logic       clock,
    input  wire logic       ale,
    input  wire logic       slow,
    input  wire logic [7:0] ad_out,
    input  wire logic       as_n,
    input  wire logic       ds_n,
    input  wire logic       ds2_n,
    input  wire logic       rw_n,
    output logic      [7:0] ad_in,
    output logic            stall_n
);
    logic [7:0] mem [256];
    logic [7:0] addr_reg;
    logic [7:0] last_reg;
    logic       held_reg;
    logic       strobe;
    assign strobe  = !ds_n || !ds2_n;
    // Slow memory holds wait for one extra clock per strobe
    assign stall_n = !(slow && strobe && !held_reg);
    // Data valid through the strobe; never the stale value after it
    assign ad_in   = (strobe && rw_n) ? mem[addr_reg] : ~last_reg;
    always_ff @(posedge clock) begin
        last_reg <= ad_in;
        held_reg <= strobe;
        if (as_n == ale) begin
            addr_reg <= ad_out;
        end
        if (!rw_n && (ale || strobe)) begin
            mem[addr_reg] <= ad_out;
        end
    end
endmodule

// >>> tb/tb_external_memory_bus_interface.sv
// Purpose: Self-checking bench for the external memory bus interface
// Assumes: Registers over APB, byte address four times the index
// Notes:   Table of ordinary accesses first, awkward cases after it
`timescale 1ns/1ps
module tb_external_memory_bus_interface;
    typedef struct packed {
        logic [7:0]  cfg;
        logic        w;
        logic        i;
        logic [21:0] a;
        logic [7:0]  d;
    } emi_row_t;
    localparam logic [11:0] CFG_A  = {emi_pkg::CFG1_IDX, 2'b00};
    localparam logic [11:0] MODE_A = {emi_pkg::MODE_IDX, 2'b00};
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic        acc_req, acc_write, acc_internal, acc_done, acc_busy, ad_oe, hi_oe;
    logic        as_n, as_oe, ds_n, ds_oe, ds2_n, ds2_oe, rw_n, rw_oe, stall_n;
    logic        bus_request_n_n, grant_n, drive, pull, ale, slow, top, top_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [21:0] acc_addr;
    logic [7:0]  acc_wdata, acc_rdata, ad_in, ad_out, hi_out, wd2;
    logic [6:0]  oe1;
    logic [19:0] s1;
    logic [11:0] s2;
    int          fail_count, n_compared, cyc, nlow, n;
    emi_row_t    r = '0;
    emi_row_t    rows [10] = '{
        '{8'h92, 1'b1, 1'b0, 22'h200012, 8'ha5}, '{8'h90, 1'b0, 1'b0, 22'h200012, 8'ha5},
        '{8'hb0, 1'b1, 1'b0, 22'h000034, 8'h3c}, '{8'hb2, 1'b0, 1'b0, 22'h000034, 8'h3c},
        '{8'ha0, 1'b0, 1'b0, 22'h200012, 8'ha5}, '{8'hd0, 1'b1, 1'b0, 22'h200056, 8'h77},
        '{8'hd0, 1'b0, 1'b0, 22'h200056, 8'h77}, '{8'hf0, 1'b0, 1'b0, 22'h000034, 8'h3c},
        '{8'h90, 1'b0, 1'b1, 22'h200012, 8'ha5}, '{8'h95, 1'b0, 1'b1, 22'h200012, 8'ha5}};
    // ****************************************
    // Design and far side
    // ****************************************
    emi_core dut (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .acc_req(acc_req),
        .acc_write(acc_write), .acc_internal(acc_internal), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_done(acc_done), .acc_rdata(acc_rdata),
        .acc_busy(acc_busy), .protect_off(r.cfg[0]), .ad_in(ad_in), .ad_out(ad_out),
        .ad_oe(ad_oe), .addr_hi_out(hi_out), .addr_hi_oe(hi_oe), .addr_top_out(top),
        .addr_top_oe(top_oe), .addr_strobe_n_out(as_n), .addr_strobe_n_oe(as_oe),
        .data_strobe_n_out(ds_n), .data_strobe_n_oe(ds_oe),
        .lower_block_strobe_n_out(ds2_n), .lower_block_strobe_n_oe(ds2_oe),
        .rw_n_out(rw_n), .rw_n_oe(rw_oe), .stall_n(stall_n), .bus_request_n(bus_request_n_n),
        .bus_grant_n(grant_n), .drive_strength(drive), .weak_pullup_en(pull));
    emi_mem_model mem (.clock(clock), .ale(ale), .slow(slow), .ad_out(ad_out),
        .as_n(as_n), .ds_n(ds_n), .ds2_n(ds2_n), .rw_n(rw_n), .ad_in(ad_in),
        .stall_n(stall_n));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict();
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic limit_hit();
        fail_count++;
        $display("ERROR %0t wait limit reached", $time);
        print_verdict();
    endtask
    // Request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        err = pslverr;
        if (n >= 20) limit_hit();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic access(input logic w, input logic i, input logic [21:0] a, input logic [7:0] d);
        acc_req <= 1'b1;
        acc_write <= w;
        acc_internal <= i;
        acc_addr <= a;
        acc_wdata <= d;
        @(posedge clock);
        acc_req <= 1'b0;
        cyc = 0;
        nlow = 0;
        do begin
            @(negedge clock);
            cyc++;
            if (ds_n === 1'b0 || ds2_n === 1'b0) nlow++;
            if (cyc == 1) oe1 = {as_oe, ds_oe, ds2_oe, rw_oe, ad_oe, hi_oe, top_oe};
            if (cyc == 1) s1 = {acc_busy, as_n, rw_n, top, hi_out, ad_out};
            if (cyc == 2) s2 = {ds_n, ds2_n, rw_n, ad_oe, hi_out};
            if (cyc == 2) wd2 = ad_out;
        end while (acc_done !== 1'b1 && cyc < 20);
        if (cyc >= 20) limit_hit();
        @(posedge clock);
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        {rst_n, psel, penable, pwrite, acc_req, acc_write, acc_internal, slow, ale} = '0;
        {paddr, pwdata, acc_addr, acc_wdata} = '0;
        bus_request_n_n = 1'b1;
        fail_count = 0;
        n_compared = 0;
        @(posedge clock);
        @(negedge clock);
        check(32'({pull, as_n, ds_n, as_oe, ds_oe, rw_oe}), 32'h38, "reset pins");
        @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        apb(1'b0, CFG_A, 32'h0);
        check(rdat, 32'h80, "config reset");
        apb(1'b0, MODE_A, 32'h0);
        check(rdat, 32'h0, "mode reset");
        apb(1'b1, CFG_A, 32'hff);
        apb(1'b0, CFG_A, 32'h0);
        check(rdat, 32'hf6, "config write mask");
        apb(1'b0, 12'h000, 32'h0);
        check({rdat[30:0], err}, 32'h1, "unmapped read");
        foreach (rows[k]) begin
            r = rows[k];
            ale <= r.cfg[6];
            apb(1'b1, CFG_A, 32'(r.cfg));
            @(posedge clock);
            check(32'(drive), 32'(r.cfg[1]), "drive strength");
            access(r.w, r.i, r.a, r.d);
            check(32'(cyc), 32'd3, "cycle length");
            if (r.i) begin
                check(32'(s2[11:10]), 32'h3, "internal strobes");
                check(32'(s1[18]), 32'(!(r.cfg[2] & r.cfg[0])), "internal toggle");
            end else begin
                check(32'(oe1), 32'({r.cfg[4], 6'h3f}), "pins driven");
                check(32'(s1), 32'({1'b1, r.cfg[6], r.cfg[6] | !r.w, r.a[21],
                    r.a[15:0]}), "address");
                check(32'(s2), 32'({r.i | (r.cfg[5] & !r.a[21]) | (r.cfg[6] & r.w),
                    r.a[21] | !r.cfg[5] | (r.cfg[6] & r.w), !r.w, r.w, r.a[15:8]}), "data");
                if (r.w) check(32'(wd2), 32'(r.d), "write data");
                if (!r.w) check(32'(acc_rdata), 32'(r.d), "read data");
            end
        end
        slow <= 1'b1;
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, MODE_A, e ? 32'h4 : 32'h0);
            access(1'b0, 1'b0, 22'h200012, 8'h0);
            check(32'({cyc[7:0], nlow[7:0], acc_rdata}),
                32'({8'(3 + e), 8'(1 + e), 8'ha5}), "stall");
        end
        slow <= 1'b0;
        apb(1'b1, MODE_A, 32'h1);
        access(1'b0, 1'b0, 22'h200012, 8'h0);
        check(32'(oe1), 32'h0, "bus float");
        apb(1'b1, MODE_A, 32'h0);
        bus_request_n_n <= 1'b0;
        access(1'b0, 1'b0, 22'h200012, 8'h0);
        check(32'(grant_n), 32'h1, "request disabled");
        apb(1'b1, MODE_A, 32'h2);
        access(1'b0, 1'b0, 22'h200012, 8'h0);
        @(negedge clock);
        check(32'({grant_n, as_oe, ds_oe, rw_oe, ad_oe, hi_oe}), 32'h0, "granted");
        @(posedge clock);
        apb(1'b0, {emi_pkg::STAT_IDX, 2'b00}, 32'h0);
        check(rdat, 32'h18, "status in hold");
        bus_request_n_n <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (grant_n !== 1'b1 && n < 5);
        check(32'(grant_n), 32'h1, "bus taken back");
        print_verdict();
    end
endmodule
